// ==== rtl/humidity_readout_pkg.sv ====
package humidity_readout_pkg;

   // fixed serial slave address
   localparam logic [6:0] SLAVE_ADDR      = 7'h44;
   // clock and measurement times, ns
   localparam int         CLK_PERIOD_NS   = 100;
   localparam int         WAKE_NS         = 100000;
   localparam int         CONV_8_NS       = 550000;
   localparam int         CONV_10_NS      = 1310000;
   localparam int         CONV_12_NS      = 4500000;
   localparam int         CONV_14_NS      = 16900000;
   localparam int         WAKE_CYCLES     = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         CNT_W           = 18;
   localparam int         BYTE_BITS       = 8;

   // resolution codes
   localparam logic [1:0] RES_8           = 2'h0;
   localparam logic [1:0] RES_10          = 2'h1;
   localparam logic [1:0] RES_12          = 2'h2;
   localparam logic [1:0] RES_14          = 2'h3;
   localparam logic [1:0] RES_DEFAULT     = RES_14;
   // result masks, lower resolutions scaled into 14 bits
   localparam logic [13:0] MASK_8         = 14'h3FC0;
   localparam logic [13:0] MASK_10        = 14'h3FF0;
   localparam logic [13:0] MASK_12        = 14'h3FFC;
   localparam logic [13:0] MASK_14        = 14'h3FFF;
   // status codes in byte one
   localparam logic [1:0] STAT_VALID      = 2'h0;
   localparam logic [1:0] STAT_STALE      = 2'h1;

   // register map
   localparam logic [7:0] REG_CONFIG      = 8'h00;
   localparam logic [7:0] REG_STATUS      = 8'h04;
   localparam logic [7:0] REG_RESULT      = 8'h08;
   localparam int         CFG_HRES_LSB    = 0;
   localparam int         CFG_TRES_LSB    = 2;
   localparam int         STAT_BUSY_BIT   = 0;
   localparam int         STAT_STALE_BIT  = 1;
   localparam int         STAT_DONE_BIT   = 2;
   localparam int         STAT_FETCH_BIT  = 3;
   localparam logic [1:0] RESP_OKAY       = 2'h0;
   localparam logic [1:0] RESP_SLVERR     = 2'h2;

   typedef enum logic [2:0] {
      L_IDLE    = 3'h0,
      L_ADDR    = 3'h1,
      L_ADDR_ACK= 3'h2,
      L_RX      = 3'h3,
      L_TX      = 3'h4,
      L_TX_ACK  = 3'h5,
      L_IGNORE  = 3'h6
   } link_state_t;

   typedef enum logic [2:0] {
      M_SLEEP   = 3'h0,
      M_WAKE    = 3'h1,
      M_HUM     = 3'h2,
      M_TEMP    = 3'h3,
      M_CORR    = 3'h4
   } meas_state_t;

   typedef struct packed {
      logic [7:0]  awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [7:0]  araddr;
      logic        arvalid;
      logic        rready;
   } axil_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } axil_rsp_t;

   typedef struct packed {
      logic [13:0] hum;
      logic [13:0] temp;
   } sample_t;

endpackage

// ==== rtl/humidity_temp_i2c_readout.sv ====
`timescale 1ns/1ns

// Operation
// [R1] serial slave at 100 and 400 kHz
// [R2] acknowledge only address 44 hex
// [R3] eighth bit one reads, zero writes
// [R4] eight data bits then one response bit
// [R5] sample on rise, change only while low
// [R6] master frames with start and stop
// [R7] sleep until a measurement request
// [R8] address plus write starts measurement
// [R9] humidity, temperature, correction, then update
// [R10] results always 14 bits, msb first
// [R11] address plus read acknowledged, bytes follow
// [R12] status, humidity, then temperature bytes
// [R13] master drops two lsbs of byte four
// [R14] master nack ends sending early
// [R15] status valid until fetched, then stale
// [R16] stale before first measurement completes
// [R17] equal resolutions give listed total times
// [R18] mixed times sum plus wake-up
// [R19] master polls status or waits
// [R20] two-bit resolution codes, default 14
// [R21] per-quantity conversion times by resolution
// [R22] status 00 valid, 01 stale
// [R23] fetch during measurement returns old, stale
module humidity_temp_i2c_readout
   import humidity_readout_pkg::*;
#(
   parameter int conv_cycles_8  = (CONV_8_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
   parameter int conv_cycles_10 = (CONV_10_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
   parameter int conv_cycles_12 = (CONV_12_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
   parameter int conv_cycles_14 = (CONV_14_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
) (
   input  wire logic      aclk,
   input  wire logic      aresetn,
   input  wire axil_req_t axi_req,
   output axil_rsp_t      axi_rsp,
   input  wire logic      scl_in,
   input  wire logic      sda_in,
   output logic           sda_out,
   output logic           sda_oe,
   input  wire sample_t   front_end
);

   // whole module state
   typedef struct packed {
      logic [2:0]   scl_s;      // scl synchroniser chain
      logic [2:0]   sda_s;      // sda synchroniser chain
      logic         scl_f;      // agreed scl level
      logic         sda_f;      // agreed sda level
      link_state_t  link;       // serial slave state
      logic [3:0]   bitcnt;     // bits seen in this byte
      logic [7:0]   shreg;      // byte being moved
      logic [31:0]  txword;     // remaining fetch bytes
      logic [1:0]   byte_idx;   // byte of fetch in flight
      logic         rw;         // direction of this transfer
      logic         ack_ok;     // master acked last byte
      logic         fetched;    // byte one went out
      logic         drive;      // pulling sda low
      meas_state_t  meas;       // measurement sequencer
      logic [CNT_W-1:0] cnt;    // phase countdown
      logic [1:0]   hres;       // configured humidity resolution
      logic [1:0]   tres;       // configured temperature resolution
      logic [1:0]   hres_act;   // resolution of running cycle
      logic [1:0]   tres_act;
      sample_t      raw;        // captured conversions
      sample_t      result;     // output register
      logic         stale;      // result already fetched
      logic         first_done; // a cycle has completed
      logic [7:0]   awaddr;     // held write address
      logic         have_aw;
      logic [31:0]  wdata;      // held write data
      logic [3:0]   wstrb;
      logic         have_w;
      logic         bvalid;
      logic [1:0]   bresp;
      logic         rvalid;
      logic [31:0]  rdata;
      logic [1:0]   rresp;
   } state_t;

   state_t q;                   // registered state
   state_t n;                   // next state
   logic   scl_rise;            // agreed scl edges
   logic   scl_fall;
   logic   start_c;             // start or repeated start
   logic   stop_c;              // stop condition
   logic   go;                  // measurement request accepted
   logic   busy;                // sequencer awake

   // [R17] conversion length for a resolution code
   function automatic logic [CNT_W-1:0] conv_len(input logic [1:0] r);
      case (r)
         RES_8:   conv_len = CNT_W'(conv_cycles_8 - 1);
         RES_10:  conv_len = CNT_W'(conv_cycles_10 - 1);
         RES_12:  conv_len = CNT_W'(conv_cycles_12 - 1);
         default: conv_len = CNT_W'(conv_cycles_14 - 1);
      endcase
   endfunction

   // mask that scales a reading to 14 bits
   function automatic logic [13:0] res_mask(input logic [1:0] r);
      case (r)
         RES_8:   res_mask = MASK_8;
         RES_10:  res_mask = MASK_10;
         RES_12:  res_mask = MASK_12;
         default: res_mask = MASK_14;
      endcase
   endfunction

   // next-state logic for link, sequencer and bus slave
   always_comb begin
      n = q;
      busy = (q.meas != M_SLEEP);
      go = 1'b0;
      n.scl_s = {q.scl_s[1:0], scl_in};
      n.sda_s = {q.sda_s[1:0], sda_in};
      // a level counts once second and third stages agree
      if (q.scl_s[1] == q.scl_s[2]) begin
         n.scl_f = q.scl_s[2];
      end
      if (q.sda_s[1] == q.sda_s[2]) begin
         n.sda_f = q.sda_s[2];
      end
      scl_rise = !q.scl_f && n.scl_f;
      scl_fall = q.scl_f && !n.scl_f;
      // [R6] frame edges seen
      start_c = q.scl_f && n.scl_f && q.sda_f && !n.sda_f;
      stop_c = q.scl_f && n.scl_f && !q.sda_f && n.sda_f;

      if (start_c || stop_c) begin
         // [R15] fetch ends, data now stale
         if (q.fetched) begin
            n.stale = 1'b1;
         end
         n.fetched = 1'b0;
         n.drive = 1'b0;
         n.bitcnt = '0;
         n.link = start_c ? L_ADDR : L_IDLE;
      end else begin
         case (q.link)
            L_IDLE, L_IGNORE: begin
               // nothing driven until the next start
               n.drive = 1'b0;
            end
            L_ADDR, L_RX: begin
               // [R5] sample on rising scl
               if (scl_rise) begin
                  n.shreg = {q.shreg[6:0], q.sda_f};
                  n.bitcnt = q.bitcnt + 4'h1;
               end else if (scl_fall && q.bitcnt == 4'(BYTE_BITS)) begin
                  n.bitcnt = '0;
                  // [R2] only the fixed address
                  if (q.link == L_ADDR && q.shreg[7:1] == SLAVE_ADDR) begin
                     // [R4] acknowledge is a low response bit
                     n.drive = 1'b1;
                     // [R3] direction bit
                     n.rw = q.shreg[0];
                     n.link = L_ADDR_ACK;
                     // [R12] snapshot result with status on top
                     // [R22] status encoding
                     // [R23] running cycle reports old data as stale
                     n.txword = {(q.stale || busy) ? STAT_STALE : STAT_VALID,
                                 q.result.hum, q.result.temp, 2'h0};
                     // [R8] write direction requests a measurement
                     // [R7] sleep until asked
                     go = !q.shreg[0] && !busy;
                  end else begin
                     // written data bytes are not taken
                     n.link = L_IGNORE;
                  end
               end
            end
            L_ADDR_ACK: begin
               if (scl_fall) begin
                  n.bitcnt = '0;
                  if (q.rw) begin
                     // [R11] first fetch byte follows the ack
                     n.shreg = q.txword[31:24];
                     n.txword = {q.txword[23:0], 8'h00};
                     n.drive = !q.txword[31];
                     n.byte_idx = '0;
                     n.link = L_TX;
                  end else begin
                     n.drive = 1'b0;
                     n.link = L_RX;
                  end
               end
            end
            L_TX: begin
               if (scl_rise) begin
                  n.bitcnt = q.bitcnt + 4'h1;
               end else if (scl_fall) begin
                  // [R5] data changes only while scl low
                  if (q.bitcnt == 4'(BYTE_BITS)) begin
                     n.drive = 1'b0;
                     n.bitcnt = '0;
                     n.ack_ok = 1'b0;
                     n.link = L_TX_ACK;
                  end else begin
                     // [R10] msb first
                     n.shreg = {q.shreg[6:0], 1'b0};
                     n.drive = !q.shreg[6];
                  end
               end
            end
            L_TX_ACK: begin
               if (scl_rise) begin
                  n.ack_ok = !q.sda_f;
                  if (q.byte_idx == 2'h0) begin
                     n.fetched = 1'b1;
                  end
               end else if (scl_fall) begin
                  // [R14] nack or fourth byte ends sending
                  if (!q.ack_ok || q.byte_idx == 2'h3) begin
                     n.link = L_IGNORE;
                  end else begin
                     n.byte_idx = q.byte_idx + 2'h1;
                     n.shreg = q.txword[31:24];
                     n.txword = {q.txword[23:0], 8'h00};
                     n.drive = !q.txword[31];
                     n.link = L_TX;
                  end
               end
            end
            default: begin
               n.link = L_IDLE;
               n.drive = 1'b0;
            end
         endcase
      end

      // measurement sequencer
      case (q.meas)
         M_SLEEP: begin
            if (go) begin
               // [R18] wake-up first; resolution frozen for the cycle
               n.hres_act = q.hres;
               n.tres_act = q.tres;
               n.cnt = CNT_W'(WAKE_CYCLES - 1);
               n.meas = M_WAKE;
            end
         end
         M_WAKE: begin
            if (q.cnt == '0) begin
               // [R21] humidity time per resolution
               n.cnt = conv_len(q.hres_act);
               n.meas = M_HUM;
            end else begin
               n.cnt = q.cnt - 1'b1;
            end
         end
         M_HUM: begin
            if (q.cnt == '0) begin
               // [R9] humidity before temperature
               n.raw.hum = front_end.hum;
               n.cnt = conv_len(q.tres_act);
               n.meas = M_TEMP;
            end else begin
               n.cnt = q.cnt - 1'b1;
            end
         end
         M_TEMP: begin
            if (q.cnt == '0) begin
               n.raw.temp = front_end.temp;
               n.meas = M_CORR;
            end else begin
               n.cnt = q.cnt - 1'b1;
            end
         end
         M_CORR: begin
            // [R10] scale into 14 bits
            n.result.hum = q.raw.hum & res_mask(q.hres_act);
            n.result.temp = q.raw.temp & res_mask(q.tres_act);
            // [R15] a finished cycle wins over a same-cycle fetch end
            n.stale = 1'b0;
            n.first_done = 1'b1;
            n.meas = M_SLEEP;
         end
         default: begin
            n.meas = M_SLEEP;
         end
      endcase

      // bus slave: address and data taken in either order
      if (axi_req.awvalid && !q.have_aw && !q.bvalid) begin
         n.awaddr = axi_req.awaddr;
         n.have_aw = 1'b1;
      end
      if (axi_req.wvalid && !q.have_w && !q.bvalid) begin
         n.wdata = axi_req.wdata;
         n.wstrb = axi_req.wstrb;
         n.have_w = 1'b1;
      end
      if (q.have_aw && q.have_w) begin
         n.have_aw = 1'b0;
         n.have_w = 1'b0;
         n.bvalid = 1'b1;
         if (q.awaddr == REG_CONFIG) begin
            n.bresp = RESP_OKAY;
            // [R20] independent resolution codes
            if (q.wstrb[0]) begin
               n.hres = q.wdata[CFG_HRES_LSB +: 2];
               n.tres = q.wdata[CFG_TRES_LSB +: 2];
            end
         end else begin
            n.bresp = RESP_SLVERR;
         end
      end
      if (q.bvalid && axi_req.bready) begin
         n.bvalid = 1'b0;
      end
      if (axi_req.arvalid && !q.rvalid) begin
         n.rvalid = 1'b1;
         n.rresp = RESP_OKAY;
         n.rdata = '0;
         case (axi_req.araddr)
            REG_CONFIG: begin
               n.rdata[CFG_HRES_LSB +: 2] = q.hres;
               n.rdata[CFG_TRES_LSB +: 2] = q.tres;
            end
            REG_STATUS: begin
               n.rdata[STAT_BUSY_BIT] = busy;
               // [R16] stale until a first cycle completes
               n.rdata[STAT_STALE_BIT] = q.stale;
               n.rdata[STAT_DONE_BIT] = q.first_done;
               n.rdata[STAT_FETCH_BIT] = (q.link == L_TX) || (q.link == L_TX_ACK);
            end
            REG_RESULT: begin
               n.rdata = {q.result.hum, 2'h0, q.result.temp, 2'h0};
            end
            default: begin
               n.rresp = RESP_SLVERR;
            end
         endcase
      end else if (q.rvalid && axi_req.rready) begin
         n.rvalid = 1'b0;
      end
   end

   // single state register, synchronous reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.scl_s <= 3'h7;
         q.sda_s <= 3'h7;
         q.scl_f <= 1'b1;
         q.sda_f <= 1'b1;
         q.link <= L_IDLE;
         q.meas <= M_SLEEP;
         q.hres <= RES_DEFAULT;
         q.tres <= RES_DEFAULT;
         q.hres_act <= RES_DEFAULT;
         q.tres_act <= RES_DEFAULT;
         // [R16] nothing fetched is ever valid before a first cycle
         q.stale <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // open-drain data: only ever pulls low
   // [R1] line timing follows the sampled bus clock, no stretching
   assign sda_out = 1'b0;
   assign sda_oe = q.drive;

   // bus answers; readies are combinational, one driver for the whole struct
   assign axi_rsp = '{awready: !q.have_aw && !q.bvalid,
                      wready:  !q.have_w && !q.bvalid,
                      bresp:   q.bresp,
                      bvalid:  q.bvalid,
                      arready: !q.rvalid,
                      rdata:   q.rdata,
                      rresp:   q.rresp,
                      rvalid:  q.rvalid};

endmodule // humidity_temp_i2c_readout

// ==== verif/humidity_readout_props.sv ====
`timescale 1ns/1ns
// port-level checks on the sensor readout
module humidity_readout_props
   import humidity_readout_pkg::*;
(
   input  wire logic      aclk,
   input  wire logic      aresetn,
   input  wire axil_req_t axi_req,
   input  wire axil_rsp_t axi_rsp,
   input  wire logic      scl_in,
   input  wire logic      sda_in,
   input  wire logic      sda_out,
   input  wire logic      sda_oe,
   input  wire sample_t   front_end
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [7:0] oe_run;  // bus clock falls seen while the device pulls data low
   logic [7:0] hi_run;  // cycles the bus clock has stood high
   logic       scl_q;   // bus clock one cycle back
   // saturating run counters, so long idles cannot wrap
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         oe_run <= 8'h00;
         hi_run <= 8'h00;
         scl_q  <= 1'b1;
      end else begin
         scl_q  <= scl_in;
         if (!sda_oe) begin
            oe_run <= 8'h00;
         end else if (scl_q && !scl_in && oe_run != 8'hFF) begin
            oe_run <= oe_run + 8'h01;
         end
         hi_run <= !scl_in ? 8'h00 : (hi_run == 8'hFF ? hi_run : hi_run + 8'h01);
      end
   end
   sequence s_wr_take;
      axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
   endsequence
   sequence s_rd_take;
      axi_req.arvalid && axi_rsp.arready;
   endsequence
   property p_oe_steady;
      scl_in && $past(scl_in) |-> $stable(sda_oe);
   endproperty
   a_oe_steady: assert property (p_oe_steady) else $error("data moved while clock high");
   // address ack plus eight zero data bits is the longest legal pull
   property p_oe_run;
      oe_run <= 8'h09;
   endproperty
   a_oe_run: assert property (p_oe_run) else $error("data held low too long");
   property p_idle_release;
      hi_run > 8'h0B |-> !sda_oe;
   endproperty
   a_idle_release: assert property (p_idle_release) else $error("data pulled on idle bus");
   // open drain: an enabled pin may only pull low
   property p_oe_pull;
      sda_oe |-> !sda_out;
   endproperty
   a_oe_pull: assert property (p_oe_pull) else $error("data driven high");
   property p_wr_answer;
      s_wr_take |=> ##1 axi_rsp.bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("no write response");
   property p_wr_bad;
      s_wr_take ##0 (axi_req.awaddr != REG_CONFIG) |=> ##1 axi_rsp.bresp == RESP_SLVERR;
   endproperty
   a_wr_bad: assert property (p_wr_bad) else $error("bad write address accepted");
   property p_rd_answer;
      s_rd_take |=> axi_rsp.rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("no read response");
   property p_rd_bad;
      s_rd_take ##0 (axi_req.araddr != REG_CONFIG && axi_req.araddr != REG_STATUS
         && axi_req.araddr != REG_RESULT) |=> axi_rsp.rresp == RESP_SLVERR
         && axi_rsp.rdata == 32'h0;
   endproperty
   a_rd_bad: assert property (p_rd_bad) else $error("bad read address accepted");
   property p_rd_cfg;
      s_rd_take ##0 (axi_req.araddr == REG_CONFIG) |=> axi_rsp.rdata[31:4] == 28'h0;
   endproperty
   a_rd_cfg: assert property (p_rd_cfg) else $error("config spare bits set");
endmodule // humidity_readout_props
bind humidity_temp_i2c_readout humidity_readout_props u_props (.aclk(aclk),
   .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .front_end(front_end));

// ==== verif/i2c_master_model.sv ====
`timescale 1ns/1ns
// two-wire bus master; clock stands high between frames
module i2c_master_model (
   input  wire logic aclk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // change mid-low, sample late in high
   task automatic bit_slot(input logic drive_low, output logic seen);
      tick(2);
      sda_low <= drive_low;
      tick(3);
      scl <= 1'b1;
      tick(2);
      @(negedge aclk) seen = sda_line;
      @(posedge aclk) scl <= 1'b0;
   endtask
   // start, address byte, n bytes read, stop
   task automatic xfer(input logic [7:0] ab, input int n, output logic ack,
                       output logic [31:0] data);
      logic b;
      data = 32'h0;
      sda_low <= 1'b1;
      tick(4);
      scl <= 1'b0;
      for (int i = 7; i >= 0; i--) bit_slot(!ab[i], b);
      bit_slot(1'b0, b);
      ack = !b;
      for (int k = 0; k < n && ack; k++) begin
         for (int i = 0; i < 8; i++) begin
            bit_slot(1'b0, b);
            data = {data[30:0], b};
         end
         // ack all but the last byte
         bit_slot(k < n - 1, b);
      end
      tick(2);
      sda_low <= 1'b1;
      tick(3);
      scl <= 1'b1;
      tick(3);
      sda_low <= 1'b0;
      tick(8);
   endtask
endmodule // i2c_master_model

// ==== verif/humidity_temp_i2c_readout_tb.sv ====
`timescale 1ns/1ns
// self-checking bench: register bus and serial fetches against a model
module humidity_temp_i2c_readout_tb;
   import humidity_readout_pkg::*;
   logic        aclk;
   logic        aresetn;
   axil_req_t   axi_req;
   axil_rsp_t   axi_rsp;
   sample_t     front_end;
   logic        scl;
   logic        sda_low;
   logic        sda_out;
   logic        sda_oe;
   wire         sda_line = !(sda_oe || sda_low);  // pull-up unless pulled
   int          error_cnt = 0;
   int          compares = 0;
   int          code, tc, n, t0, el, e, have;
   logic [31:0] d;
   logic [1:0]  r;
   logic        ack;
   logic [13:0] h, t, mh, mt, ph, pt;
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   humidity_temp_i2c_readout #(.conv_cycles_8(20), .conv_cycles_10(30),
      .conv_cycles_12(40), .conv_cycles_14(50)) u_dut (.aclk(aclk), .aresetn(aresetn),
      .axi_req(axi_req), .axi_rsp(axi_rsp), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .front_end(front_end));
   i2c_master_model u_mst (.aclk(aclk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // write with address and data offered together
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic aw, w, b;
      axi_req.awaddr <= a;
      axi_req.wdata <= v;
      axi_req.wstrb <= 4'hF;
      axi_req.awvalid <= 1'b1;
      axi_req.wvalid <= 1'b1;
      axi_req.bready <= 1'b1;
      do begin
         @(negedge aclk);
         aw = axi_rsp.awready;
         w = axi_rsp.wready;
         b = axi_rsp.bvalid;
         rs = axi_rsp.bresp;
         @(posedge aclk);
         if (aw) axi_req.awvalid <= 1'b0;
         if (w) axi_req.wvalid <= 1'b0;
      end while (!b);
      axi_req.bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      logic ar, rv;
      axi_req.araddr <= a;
      axi_req.arvalid <= 1'b1;
      axi_req.rready <= 1'b1;
      do begin
         @(negedge aclk);
         ar = axi_rsp.arready;
         rv = axi_rsp.rvalid;
         v = axi_rsp.rdata;
         rs = axi_rsp.rresp;
         @(posedge aclk);
         if (ar) axi_req.arvalid <= 1'b0;
      end while (!rv);
      axi_req.rready <= 1'b0;
      // let an edge pass so a following read never reassigns rready in this step
      @(posedge aclk);
   endtask
   // hang guard, several times the expected run
   initial begin
      repeat (60000) @(posedge aclk);
      error_cnt++;
      finish_test;
   end
   initial begin
      aresetn = 1'b0;
      axi_req = '0;
      front_end = '0;
      have = 0;
      void'($urandom(4133));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (6) @(posedge aclk);
      axi_rd(REG_CONFIG, d, r);
      check("config reset", 32'h0000000F, d);
      check("config resp", {30'h0, RESP_OKAY}, {30'h0, r});
      axi_rd(8'h0C, d, r);
      check("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r});
      axi_wr(8'h10, 32'h0, r);
      check("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
      u_mst.xfer(8'h8A, 0, ack, d);
      check("foreign ack", 32'h0, {31'h0, ack});
      u_mst.xfer({SLAVE_ADDR, 1'b1}, 1, ack, d);
      check("early status", {30'h0, STAT_STALE}, {30'h0, d[7:6]});
      // every resolution code, humidity and temperature differing
      for (code = 0; code < 4; code++) begin
         tc = (code + 1) % 4;
         axi_wr(REG_CONFIG, 32'(code | (tc << 2)), r);
         h = 14'($urandom);
         t = 14'($urandom);
         front_end <= {h, t};
         u_mst.xfer({SLAVE_ADDR, 1'b0}, 0, ack, d);
         t0 = int'($time / 100);
         check("request ack", 32'h1, {31'h0, ack});
         u_mst.xfer({SLAVE_ADDR, 1'b1}, 2, ack, d);
         check("busy fetch status", {30'h0, STAT_STALE}, {30'h0, d[15:14]});
         if (have != 0) check("busy fetch data", {18'h0, ph}, {18'h0, d[13:0]});
         axi_rd(REG_STATUS, d, r);
         check("busy flag", 32'h1, {31'h0, d[STAT_BUSY_BIT]});
         for (n = 0; n < 1000 && d[STAT_BUSY_BIT]; n++) axi_rd(REG_STATUS, d, r);
         el = int'($time / 100) - t0;
         e = WAKE_CYCLES + 1 + (20 + 10 * code) + (20 + 10 * tc);
         check("cycle length", 32'h1, {31'h0, el >= e - 36 && el <= e - 10});
         check("idle status", 32'(1 << STAT_DONE_BIT), d);
         mh = 14'h3FFF << (2 * (3 - code));
         mt = 14'h3FFF << (2 * (3 - tc));
         ph = h & mh;
         pt = t & mt;
         have = 1;
         axi_rd(REG_RESULT, d, r);
         check("result reg", {ph, 2'b00, pt, 2'b00}, d);
         n = 2 + code % 3;
         u_mst.xfer({SLAVE_ADDR, 1'b1}, n, ack, d);
         check("fetch", {STAT_VALID, ph, pt, 2'b00} >> (8 * (4 - n)),
            d & (n == 4 ? 32'hFFFFFFFC : 32'hFFFFFFFF));
         u_mst.xfer({SLAVE_ADDR, 1'b1}, 1, ack, d);
         check("refetch status", {30'h0, STAT_STALE}, {30'h0, d[7:6]});
      end
      finish_test;
   end
endmodule // humidity_temp_i2c_readout_tb
